// ### shared/cdrlm_consts.svh
// Constants for the clock-recovery lock-mode controller.
// How it works
// - Reset always starts in reference-lock mode.
// - Auto: enter data-lock on ref lock, ppm, phase; detect in PCIe only.
// - Auto: ppm excess returns to reference-lock.
// - PCIe auto: signal loss returns to reference-lock.
// - Status output shows current lock mode.
// - Auto: drift from missing transitions returns reference-lock.
// - Manual: mode from two control bits; the receiver-reset bit or multiplier use forces reference-lock.
// - Phase detector off in reference-lock; ref lock first.
// - Reference-lock loop uses feedback and post-scale counters.
// - Pre-scale divide is 1, 2, 4 or 8.
// - Feedback multiply is 4,5,8,10,12,16,20,25.
// - Reference-loop post-scale is 1, 2, 4, 8.
// - Data-loop post-scale is 1, 2, 4, 8.
// - First serial bit is word LSB.
// - Word aligner drives clock slip for alignment.
// - Transmit clock multiplier use forces reference-lock.
// - Word widths 8, 10, 16 or 20.
`ifndef CDRLM_CONSTS_SVH
`define CDRLM_CONSTS_SVH
`define CDRLM_OFF_CTRL    12'h000
`define CDRLM_OFF_DIV     12'h004
`define CDRLM_OFF_STATUS  12'h008
`define CDRLM_OFF_DATA    12'h00C
`define CDRLM_CTRL_RST    6'h01
`define CDRLM_DIV_RST     11'h000
`define CDRLM_CTRL_W      6
`define CDRLM_DIV_W       11
`define CDRLM_CTL_MANUAL  0
`define CDRLM_CTL_SETDATA 1
`define CDRLM_CTL_SETREF  2
`define CDRLM_CTL_PCIE    3
`define CDRLM_CTL_CDR     4
`define CDRLM_CTL_RXRST   5
`define CDRLM_MAXW        20
`endif

// ### shared/cdrlm_pkg.sv
// Types for the clock-recovery lock-mode controller.
package cdrlm_pkg;
  typedef enum logic {CDRLM_ST_REF, CDRLM_ST_DATA} cdrlm_state_t;
  // Loop condition inputs from the analog detectors.
  typedef struct packed {
    logic ref_locked;
    logic ppm_ok;
    logic phase_ok;
    logic sig_detect;
  } cdrlm_loop_t;
  // Divider setting codes; every code maps to a legal factor.
  typedef struct packed {
    logic [1:0] width;
    logic [1:0] l_data;
    logic [1:0] l_ref;
    logic [2:0] m;
    logic [1:0] n;
  } cdrlm_div_t;
  typedef struct packed {
    logic [4:0] n;
    logic [4:0] m;
    logic [4:0] l_ref;
    logic [4:0] l_data;
  } cdrlm_fac_t;
endpackage

// ### src/cdrlm_ctrl.sv
// Lock-mode controller with divider settings, deserializer and APB registers.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "cdrlm_consts.svh"
module cdrlm_ctrl
  import cdrlm_pkg::*;
#(
  parameter int MAXW = `CDRLM_MAXW
)(
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Loop detector status.
  input  wire cdrlm_loop_t       loop_in,
  // Serial data and word aligner slip request.
  input  wire logic              ser_bit,
  input  wire logic              ser_valid,
  input  wire logic              slip_req,
  // Loop control and status.
  output logic                   rx_data_locked_status,
  output logic                   reference_lock_mode,
  output logic                   phase_det_en,
  output cdrlm_fac_t             fac_out,
  output logic [4:0]             active_post_div,
  // Parallel word.
  output logic [MAXW-1:0]        par_word,
  output logic                   par_valid
);

  cdrlm_state_t          state_r;
  cdrlm_state_t          state_nxt;
  logic [5:0]            ctrl_r;
  cdrlm_div_t            div_r;
  logic [31:0]           rdata_r;
  logic [MAXW-1:0]       shift_r;
  logic [MAXW-1:0]       shift_nxt;
  logic [MAXW-1:0]       word_mask;
  logic [MAXW-1:0]       par_word_r;
  logic                  par_valid_r;
  logic [4:0]            cnt_r;
  logic                  slip_pend_r;
  logic                  status_r;

  // Register decode.
  wire        setup     = psel & ~penable;
  wire        wr_acc    = psel & penable & pwrite;
  wire        hit_ctrl  = (paddr == `CDRLM_OFF_CTRL);
  wire        hit_div   = (paddr == `CDRLM_OFF_DIV);
  wire        hit_stat  = (paddr == `CDRLM_OFF_STATUS);
  wire        hit_data  = (paddr == `CDRLM_OFF_DATA);
  wire        hit_any   = hit_ctrl | hit_div | hit_stat | hit_data;
  wire        ro_write  = pwrite & (hit_stat | hit_data);
  wire [31:0] rd_mux    = hit_ctrl ? {26'h000_0000, ctrl_r} :
                          hit_div  ? {21'h00_0000, div_r} :
                          hit_stat ? {26'h000_0000, slip_pend_r, loop_in, status_r} :
                          hit_data ? {{(32-MAXW){1'b0}}, par_word_r} : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & (~hit_any | ro_write);
  assign prdata  = rdata_r;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r  <= `CDRLM_CTRL_RST;
      div_r   <= `CDRLM_DIV_RST;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      if (wr_acc && hit_ctrl)
        ctrl_r <= pwdata[`CDRLM_CTRL_W-1:0];
      if (wr_acc && hit_div)
        div_r <= pwdata[`CDRLM_DIV_W-1:0];
      if (setup)
        rdata_r <= rd_mux;
    end
  end

  // Control fields.
  wire manual   = ctrl_r[`CDRLM_CTL_MANUAL];
  wire set_data = ctrl_r[`CDRLM_CTL_SETDATA];
  wire set_ref  = ctrl_r[`CDRLM_CTL_SETREF];
  wire pcie     = ctrl_r[`CDRLM_CTL_PCIE];
  wire cdr_use  = ctrl_r[`CDRLM_CTL_CDR];
  wire rx_rst   = ctrl_r[`CDRLM_CTL_RXRST];

  // Entry needs reference lock, ppm and phase, plus signal in PCIe.
  wire enter_ok = loop_in.ref_locked & loop_in.ppm_ok & loop_in.phase_ok &
                  (~pcie | loop_in.sig_detect);
  wire exit_ok  = ~loop_in.ppm_ok | (pcie & ~loop_in.sig_detect);

  always_comb
  begin
    state_nxt = state_r;
    if (rx_rst || !cdr_use)
      state_nxt = CDRLM_ST_REF;
    else if (manual)
    begin
      if (set_ref)
        state_nxt = CDRLM_ST_REF;
      else if (set_data)
        state_nxt = CDRLM_ST_DATA;
      else
        state_nxt = state_r;
    end
    else
    begin
      case (state_r)
        CDRLM_ST_REF:  if (enter_ok) state_nxt = CDRLM_ST_DATA;
        CDRLM_ST_DATA: if (exit_ok) state_nxt = CDRLM_ST_REF;
        default:       state_nxt = CDRLM_ST_REF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= CDRLM_ST_REF;
    else
      state_r <= state_nxt;
  end

  wire in_data = (state_r == CDRLM_ST_DATA);
  always_comb status_r = in_data;
  assign rx_data_locked_status = status_r;
  assign reference_lock_mode   = ~in_data;
  assign phase_det_en          = in_data;

  // Divider factors; the code widths admit only legal factors.
  function automatic logic [4:0] pow2(input logic [1:0] c);
    pow2 = 5'h01 << c;
  endfunction
  function automatic logic [4:0] mfac(input logic [2:0] c);
    case (c)
      3'h0:    mfac = 5'd4;
      3'h1:    mfac = 5'd5;
      3'h2:    mfac = 5'd8;
      3'h3:    mfac = 5'd10;
      3'h4:    mfac = 5'd12;
      3'h5:    mfac = 5'd16;
      3'h6:    mfac = 5'd20;
      default: mfac = 5'd25;
    endcase
  endfunction
  function automatic logic [4:0] wlen(input logic [1:0] c);
    case (c)
      2'h0:    wlen = 5'd8;
      2'h1:    wlen = 5'd10;
      2'h2:    wlen = 5'd16;
      default: wlen = 5'd20;
    endcase
  endfunction

  assign fac_out.n      = pow2(div_r.n);
  assign fac_out.m      = mfac(div_r.m);
  assign fac_out.l_ref  = pow2(div_r.l_ref);
  assign fac_out.l_data = pow2(div_r.l_data);
  // Reference loop runs through the reference post-scale counter.
  assign active_post_div = in_data ? fac_out.l_data : fac_out.l_ref;

  // Deserializer: bit k of the word is the k-th received bit.
  wire [4:0] wl      = wlen(div_r.width);
  wire       take    = in_data & ser_valid & ~slip_pend_r;
  wire       slip_go = in_data & ser_valid & slip_pend_r;
  wire       last    = take & (cnt_r == wl - 5'd1);

  genvar gi;
  generate
    for (gi = 0; gi < MAXW; gi++)
    begin : g_bit
      assign shift_nxt[gi] = (take && cnt_r == 5'(gi)) ? ser_bit : shift_r[gi];
      assign word_mask[gi] = (5'(gi) < wl);
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shift_r     <= '0;
      cnt_r       <= 5'h00;
      par_word_r  <= '0;
      par_valid_r <= 1'b0;
      slip_pend_r <= 1'b0;
    end
    else
    begin
      shift_r     <= in_data ? shift_nxt : '0;
      cnt_r       <= (!in_data || last) ? 5'h00 : cnt_r + 5'(take);
      par_valid_r <= last;
      if (last)
        par_word_r <= shift_nxt & word_mask;
      // A new slip request wins over the slip being consumed.
      slip_pend_r <= slip_req | (slip_pend_r & ~slip_go);
    end
  end

  assign par_word  = par_word_r;
  assign par_valid = par_valid_r;

  a_reset_ref_mode: assert property (@(posedge pclk)
    $rose(presetn) |-> state_r == CDRLM_ST_REF)
    else $error("Not in reference-lock after reset.");
  a_auto_enter: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(in_data) && !$past(manual) |-> $past(enter_ok))
    else $error("Automatic data-lock entry without conditions.");
  a_auto_ppm_exit: assert property (@(posedge pclk) disable iff (!presetn)
    in_data && !manual && !loop_in.ppm_ok |=> !in_data)
    else $error("Stayed in data-lock with ppm out of range.");
  a_pcie_sd_exit: assert property (@(posedge pclk) disable iff (!presetn)
    in_data && !manual && pcie && !loop_in.sig_detect |=> !in_data)
    else $error("Stayed in data-lock after signal loss.");
  a_status_follows: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(state_r) |-> $changed(rx_data_locked_status))
    else $error("Status did not follow mode change.");
  a_manual_select: assert property (@(posedge pclk) disable iff (!presetn)
    manual && cdr_use && !rx_rst && set_data && !set_ref |=> in_data)
    else $error("Manual data-lock request ignored.");
  a_manual_ref_wins: assert property (@(posedge pclk) disable iff (!presetn)
    manual && set_ref ##1 1'b1 |-> !in_data)
    else $error("Reference-lock did not win.");
  a_phase_det_off: assert property (@(posedge pclk) disable iff (!presetn)
    reference_lock_mode |-> !phase_det_en)
    else $error("Phase detector active in reference-lock.");
  a_tx_mult_ref: assert property (@(posedge pclk) disable iff (!presetn)
    !cdr_use |=> !in_data)
    else $error("Data-lock while used as clock multiplier.");
  a_mult_legal: assert property (@(posedge pclk) disable iff (!presetn)
    fac_out.m inside {5'd4, 5'd5, 5'd8, 5'd10, 5'd12, 5'd16, 5'd20, 5'd25})
    else $error("Illegal feedback factor.");
  a_slip_drop: assert property (@(posedge pclk) disable iff (!presetn)
    slip_go && !slip_req |=> !slip_pend_r && $stable(cnt_r))
    else $error("Slip did not drop one bit.");
  a_word_len: assert property (@(posedge pclk) disable iff (!presetn)
    par_valid |-> $past(cnt_r) == $past(wl) - 5'd1)
    else $error("Word emitted at wrong length.");

endmodule
`default_nettype wire

// ### testbench/cdrlm_ser_src.sv
// Serial bit source standing in for the upstream transmitter.
`timescale 1ns/1ns
`default_nettype none
module cdrlm_ser_src (
  // Clock, reset and word request.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        go,
  input  wire logic [20:0] vec,
  input  wire logic [4:0]  nbits,
  // Serial output.
  output logic             ser_bit,
  output logic             ser_valid
);
  logic [4:0] cnt_r;
  // Between words the line toggles so a stale bit is never mistaken for data.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt_r     <= '0;
      ser_valid <= 1'b0;
      ser_bit   <= 1'b0;
    end
    else if (go && cnt_r == 5'h0)
      cnt_r <= nbits;
    else if (cnt_r != 5'h0)
    begin
      ser_bit   <= vec[nbits - cnt_r];
      ser_valid <= 1'b1;
      cnt_r     <= cnt_r - 5'h1;
    end
    else
    begin
      ser_valid <= 1'b0;
      ser_bit   <= ~ser_bit;
    end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking testbench for the lock-mode controller.
`timescale 1ns/1ns
`default_nettype none
`include "cdrlm_consts.svh"
module testbench import cdrlm_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        ser_bit, ser_valid, slip_req, go, par_valid;
  logic        rx_data_locked_status, reference_lock_mode, phase_det_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [20:0] vec;
  logic [4:0]  nbits, active_post_div;
  logic [19:0] par_word;
  cdrlm_loop_t loop_in;
  cdrlm_fac_t  fac_out;
  int          num_errors, comparisons;
  logic [4:0]  mt [8] = '{5'h04, 5'h05, 5'h08, 5'h0A, 5'h0C, 5'h10, 5'h14, 5'h19};
  localparam logic [19:0] PAT = 20'hC_3A5B;

  cdrlm_ctrl dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .loop_in, .ser_bit, .ser_valid, .slip_req, .rx_data_locked_status,
    .reference_lock_mode, .phase_det_en, .fac_out, .active_post_div, .par_word, .par_valid
  );
  cdrlm_ser_src src (.pclk, .presetn, .go, .vec, .nbits, .ser_bit, .ser_valid);

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    chk({31'h0, pslverr}, {31'h0, e});
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask

  task automatic mode(input logic e);
    // One edge lets a loop or control change reach the mode register before the read.
    @(posedge pclk);
    apb(1'b0, `CDRLM_OFF_STATUS, 32'h0, 1'b0);
    chk({28'h0, rd[0], rx_data_locked_status, reference_lock_mode, phase_det_en},
        {28'h0, e, e, ~e, e});
  endtask

  // A slip drops the leading filler bit, so the same word must come out.
  task automatic word(input int wd, input logic [1:0] wc, input logic s);
    int n;
    wr(`CDRLM_OFF_CTRL, 32'h15);
    wr(`CDRLM_OFF_DIV, {21'h0, wc, 9'h0});
    wr(`CDRLM_OFF_CTRL, 32'h13);
    mode(1'b1);
    slip_req <= s;
    @(posedge pclk);
    slip_req <= 1'b0;
    vec      <= {PAT, 1'b1} >> !s;
    nbits    <= 5'(wd + s);
    go       <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (par_valid !== 1'b1 && n < 40);
    ex = {12'h0, PAT & 20'((1 << wd) - 1)};
    chk({12'h0, par_word}, ex);
    rdc(`CDRLM_OFF_DATA, ex);
  endtask

  task automatic test_done();
    $display("Comparisons %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    loop_in  = 4'h0;
    slip_req = 1'b0;
    go       = 1'b0;
    vec      = 21'h0;
    nbits    = 5'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`CDRLM_OFF_CTRL, 32'h1);
    rdc(`CDRLM_OFF_DIV, 32'h0);
    mode(1'b0);
    loop_in <= 4'hF;
    wr(`CDRLM_OFF_CTRL, 32'h03);
    mode(1'b0);
    wr(`CDRLM_OFF_CTRL, 32'h10);
    mode(1'b1);
    loop_in <= 4'hB;
    mode(1'b0);
    loop_in <= 4'hE;
    mode(1'b1);
    wr(`CDRLM_OFF_CTRL, 32'h18);
    mode(1'b0);
    loop_in <= 4'hD;
    mode(1'b0);
    loop_in <= 4'h7;
    mode(1'b0);
    loop_in <= 4'hF;
    mode(1'b1);
    loop_in <= 4'hD;
    mode(1'b1);
    loop_in <= 4'h5;
    mode(1'b1);
    loop_in <= 4'h9;
    mode(1'b0);
    loop_in <= 4'h0;
    wr(`CDRLM_OFF_CTRL, 32'h13);
    mode(1'b1);
    wr(`CDRLM_OFF_CTRL, 32'h11);
    mode(1'b1);
    wr(`CDRLM_OFF_CTRL, 32'h17);
    mode(1'b0);
    wr(`CDRLM_OFF_CTRL, 32'h13);
    wr(`CDRLM_OFF_CTRL, 32'h03);
    mode(1'b0);
    wr(`CDRLM_OFF_CTRL, 32'h15);
    for (int i = 0; i < 8; i++)
    begin
      wr(`CDRLM_OFF_DIV, {23'h0, 2'(3 - i % 4), 2'(i % 4), 3'(i), 2'(i % 4)});
      ex = {12'h0, 5'(1 << i % 4), mt[i], 5'(1 << i % 4), 5'(8 >> i % 4)};
      chk({12'h0, fac_out}, ex);
      chk({27'h0, active_post_div}, {27'h0, 5'(1 << i % 4)});
    end
    wr(`CDRLM_OFF_CTRL, 32'h13);
    @(posedge pclk);
    chk({27'h0, active_post_div}, 32'h1);
    apb(1'b0, 12'h010, 32'h0, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, `CDRLM_OFF_STATUS, 32'h0, 1'b1);
    mode(1'b1);
    wr(`CDRLM_OFF_CTRL, 32'h33);
    mode(1'b0);
    for (int i = 0; i < 4; i++)
      word(i < 2 ? 8 + 2 * i : 16 + 4 * (i - 2), 2'(i), 1'b0);
    word(8, 2'h0, 1'b1);
    test_done();
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
